// >>> rtl/cai_top.sv
// Alarm and interrupt pin block with AXI4-Lite registers and tristated clock outputs
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cai_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Detector conditions
   input wire cai_pkg::cai_det_t det,
   // Alarm and interrupt pins
   output cai_pkg::cai_pin_t irq_or_input1_alarm_pin,
   output cai_pkg::cai_pin_t input2_alarm_pin,
   // Clock output enables
   output logic [1:0] clk_out_oe,
   // Level interrupt
   output logic irq
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [6:0] ctrl_r;
   logic [3:0] status_r;
   logic [3:0] enable_r;
   logic [1:0] clken_r;
   logic [3:0] det_r;
   logic [3:0] det_prev_r;
   logic [3:0] rise;
   logic [3:0] clr_pulse;
   logic fault1;
   logic fault2;
   logic irq_active;
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go;
   cai_pkg::cai_bus_st_t rd_st_r;

   // Word select within the register map
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
      addr_hit = (a[7:2] == off[7:2]);
   endfunction

   // Detector snapshot; inputs taken as synchronous
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         det_r <= cai_pkg::CAI_ST_RESET;
         det_prev_r <= cai_pkg::CAI_ST_RESET;
      end else begin
         det_r <= {det.fos2, det.los2, det.fos1, det.los1};
         det_prev_r <= det_r;
      end
   end

   assign rise = det_r & ~det_prev_r;

   // Offset alarm only counts when the inclusion option is set
   assign fault1 = det_r[cai_pkg::CAI_ST_LOS1] |
      (det_r[cai_pkg::CAI_ST_FOS1] & ctrl_r[cai_pkg::CAI_CTL_FOS1_INCL]);
   assign fault2 = det_r[cai_pkg::CAI_ST_LOS2] |
      (det_r[cai_pkg::CAI_ST_FOS2] & ctrl_r[cai_pkg::CAI_CTL_FOS2_INCL]);

   // ---------------------------------------------------------------
   // Write channel: address and data accepted in either order
   // ---------------------------------------------------------------
   assign wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cai_pkg::CAI_RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_hold_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_hold_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Live and status are read only; unmapped offsets error
            if (addr_hit(awaddr_r, cai_pkg::CAI_OFF_CTRL) |
                addr_hit(awaddr_r, cai_pkg::CAI_OFF_ENABLE) |
                addr_hit(awaddr_r, cai_pkg::CAI_OFF_CLEAR) |
                addr_hit(awaddr_r, cai_pkg::CAI_OFF_CLKEN)) begin
               s_axi_bresp <= cai_pkg::CAI_RESP_OKAY;
            end else begin
               s_axi_bresp <= cai_pkg::CAI_RESP_SLVERR;
            end
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control register; only the low byte lane carries fields
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ctrl_r <= cai_pkg::CAI_CTL_RESET;
      end else if (wr_go & wstrb_r[0] & addr_hit(awaddr_r, cai_pkg::CAI_OFF_CTRL)) begin
         ctrl_r <= wdata_r[6:0];
      end
   end

   // Interrupt enable register
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         enable_r <= cai_pkg::CAI_EN_RESET;
      end else if (wr_go & wstrb_r[0] & addr_hit(awaddr_r, cai_pkg::CAI_OFF_ENABLE)) begin
         enable_r <= wdata_r[3:0];
      end
   end

   // Clock output enable; cleared by reset so host must set it again
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         clken_r <= cai_pkg::CAI_CLKEN_RESET;
      end else if (wr_go & wstrb_r[0] & addr_hit(awaddr_r, cai_pkg::CAI_OFF_CLKEN)) begin
         clken_r <= wdata_r[1:0];
      end
   end

   // Clock outputs released whenever reset is low
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         clk_out_oe <= 2'h0;
      end else begin
         clk_out_oe <= clken_r;
      end
   end

   // ---------------------------------------------------------------
   // Sticky status: a new event wins over a clear in the same cycle
   // ---------------------------------------------------------------
   assign clr_pulse = (wr_go & wstrb_r[0] & addr_hit(awaddr_r, cai_pkg::CAI_OFF_CLEAR)) ?
      wdata_r[3:0] : 4'h0;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         status_r <= cai_pkg::CAI_ST_RESET;
      end else begin
         status_r <= (status_r & ~clr_pulse) | rise;
      end
   end

   assign irq_active = |(status_r & enable_r);

   // Level interrupt output
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_active;
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rd_st_r <= cai_pkg::CAI_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= cai_pkg::CAI_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         case (rd_st_r)
            cai_pkg::CAI_IDLE: begin
               if (s_axi_arvalid & ~s_axi_arready) begin
                  s_axi_arready <= 1'b1;
                  s_axi_rvalid <= 1'b1;
                  rd_st_r <= cai_pkg::CAI_RESP;
                  s_axi_rresp <= cai_pkg::CAI_RESP_OKAY;
                  if (addr_hit(s_axi_araddr, cai_pkg::CAI_OFF_CTRL)) begin
                     s_axi_rdata <= {25'h0, ctrl_r};
                  end else if (addr_hit(s_axi_araddr, cai_pkg::CAI_OFF_STATUS)) begin
                     s_axi_rdata <= {28'h0, status_r};
                  end else if (addr_hit(s_axi_araddr, cai_pkg::CAI_OFF_ENABLE)) begin
                     s_axi_rdata <= {28'h0, enable_r};
                  end else if (addr_hit(s_axi_araddr, cai_pkg::CAI_OFF_CLEAR)) begin
                     s_axi_rdata <= 32'h0000_0000; // Write-only
                  end else if (addr_hit(s_axi_araddr, cai_pkg::CAI_OFF_LIVE)) begin
                     s_axi_rdata <= {28'h0, det_r};
                  end else if (addr_hit(s_axi_araddr, cai_pkg::CAI_OFF_CLKEN)) begin
                     s_axi_rdata <= {30'h0, clken_r};
                  end else begin
                     s_axi_rdata <= 32'h0000_0000;
                     s_axi_rresp <= cai_pkg::CAI_RESP_SLVERR;
                  end
               end
            end
            cai_pkg::CAI_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_st_r <= cai_pkg::CAI_IDLE;
               end
            end
            default: begin
               rd_st_r <= cai_pkg::CAI_IDLE;
               s_axi_rvalid <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   logic pin1_en;
   logic pin1_act;
   logic pin1_inv;

   // Interrupt mode takes priority over alarm mode on the shared pin
   always_comb begin
      if (ctrl_r[cai_pkg::CAI_CTL_IRQ_PIN_SEL]) begin
         pin1_en = 1'b1;
         pin1_act = irq_active;
         pin1_inv = ~ctrl_r[cai_pkg::CAI_CTL_IRQ_POL];
      end else if (ctrl_r[cai_pkg::CAI_CTL_IN1_PIN_EN]) begin
         pin1_en = 1'b1;
         pin1_act = fault1;
         pin1_inv = ~ctrl_r[cai_pkg::CAI_CTL_ALARM_POL];
      end else begin
         pin1_en = 1'b0;
         pin1_act = 1'b0;
         pin1_inv = 1'b0;
      end
   end

   // Combined interrupt / input-1 alarm pin
   cai_pin_drv u_pin1 (
      .clock(clock),
      .rst_b(rst_b),
      .enable(pin1_en),
      .active(pin1_act),
      .invert(pin1_inv),
      .pin(irq_or_input1_alarm_pin)
   );

   // Input-2 alarm pin, same shared polarity
   cai_pin_drv u_pin2 (
      .clock(clock),
      .rst_b(rst_b),
      .enable(ctrl_r[cai_pkg::CAI_CTL_IN2_PIN_EN]),
      .active(fault2),
      .invert(~ctrl_r[cai_pkg::CAI_CTL_ALARM_POL]),
      .pin(input2_alarm_pin)
   );
endmodule // cai_top
`default_nettype wire

// >>> rtl/cai_pkg.sv
// Package with register map, field positions, reset values and types for the alarm/irq pin block
package cai_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] CAI_OFF_CTRL = 8'h00;
   localparam logic [7:0] CAI_OFF_STATUS = 8'h04;
   localparam logic [7:0] CAI_OFF_ENABLE = 8'h08;
   localparam logic [7:0] CAI_OFF_CLEAR = 8'h0C;
   localparam logic [7:0] CAI_OFF_LIVE = 8'h10;
   localparam logic [7:0] CAI_OFF_CLKEN = 8'h14;

   // ---------------------------------------------------------------
   // Control register field positions
   // ---------------------------------------------------------------
   localparam int CAI_CTL_IRQ_PIN_SEL = 0;
   localparam int CAI_CTL_IRQ_POL = 1;
   localparam int CAI_CTL_IN1_PIN_EN = 2;
   localparam int CAI_CTL_IN2_PIN_EN = 3;
   localparam int CAI_CTL_ALARM_POL = 4;
   localparam int CAI_CTL_FOS1_INCL = 5;
   localparam int CAI_CTL_FOS2_INCL = 6;
   localparam int CAI_CTL_W = 7;
   localparam logic [6:0] CAI_CTL_RESET = 7'h00;

   // ---------------------------------------------------------------
   // Status / enable bit layout
   // ---------------------------------------------------------------
   localparam int CAI_ST_LOS1 = 0;
   localparam int CAI_ST_FOS1 = 1;
   localparam int CAI_ST_LOS2 = 2;
   localparam int CAI_ST_FOS2 = 3;
   localparam int CAI_ST_W = 4;
   localparam logic [3:0] CAI_ST_RESET = 4'h0;
   localparam logic [3:0] CAI_EN_RESET = 4'h0;
   localparam logic [1:0] CAI_CLKEN_RESET = 2'h0;
   localparam logic [1:0] CAI_RESP_OKAY = 2'h0;
   localparam logic [1:0] CAI_RESP_SLVERR = 2'h2;

   // Detector conditions for both reference inputs
   typedef struct packed {
      logic los1;
      logic fos1;
      logic los2;
      logic fos2;
   } cai_det_t;

   // One tristate pin: output level and output enable
   typedef struct packed {
      logic o;
      logic oe;
   } cai_pin_t;

   // Bus slave states
   typedef enum logic [1:0] {
      CAI_IDLE = 2'b00,
      CAI_RESP = 2'b01
   } cai_bus_st_t;
endpackage

// >>> rtl/cai_pin_drv.sv
// Tristate alarm/interrupt pin driver with selectable active polarity
`timescale 1ns/10ps
`default_nettype none
module cai_pin_drv (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Function select
   input wire logic enable,
   input wire logic active,
   input wire logic invert,
   // Pin
   output cai_pkg::cai_pin_t pin
);
   // Registered pin; released while in reset or unused
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pin <= '0;
      end else begin
         pin.oe <= enable;
         pin.o <= enable & (active ^ invert);
      end
   end
endmodule // cai_pin_drv
`default_nettype wire

// >>> test/cai_top_chk.sv
// Checker of pin levels, reset and bus answers for the alarm/irq pin block
`timescale 1ns/10ps
`default_nettype none
module cai_top_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Detectors and pins
   input wire cai_pkg::cai_det_t det,
   input wire cai_pkg::cai_pin_t irq_or_input1_alarm_pin,
   input wire cai_pkg::cai_pin_t input2_alarm_pin,
   input wire logic [1:0] clk_out_oe,
   input wire logic irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic [7:0] aw_q;
   logic [6:0] wd_q;
   logic wb_q;
   logic bv_q;
   logic [6:0] ctl_s;
   // ---------------------------------------------------------------
   // Shadow of the control register, snooped from the bus
   // ---------------------------------------------------------------
   // Capture address and data as each is taken
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         aw_q <= 8'h00;
         wd_q <= 7'h00;
         wb_q <= 1'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[6:0];
         if (s_axi_wvalid && s_axi_wready) wb_q <= s_axi_wstrb[0];
      end
   end
   // Commit one edge after the response rises, so it lines up with the pins
   always_ff @(posedge clock) begin
      bv_q <= rst_b && s_axi_bvalid;
      if (!rst_b) ctl_s <= 7'h00;
      else if (s_axi_bvalid && !bv_q && aw_q == cai_pkg::CAI_OFF_CTRL && wb_q) ctl_s <= wd_q;
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Settled inputs: latency of the detector path is not pinned down to one edge
   sequence s_calm(cond);
      $stable(ctl_s) && $past(det, 1) == $past(det, 2) && $past(det, 2) == $past(det, 3) && cond;
   endsequence
   a_reset_clk_off: assert property (disable iff (1'h0) !rst_b |=> clk_out_oe == 2'h0)
      else $error("clock outputs driven after reset");
   a_reset_pins_off: assert property (disable iff (1'h0) !rst_b |=>
      !irq_or_input1_alarm_pin.oe && !input2_alarm_pin.oe && !irq)
      else $error("pins or irq active after reset");
   a_irq_pin_mode: assert property (s_calm(ctl_s[0]) |-> irq_or_input1_alarm_pin.oe &&
      irq_or_input1_alarm_pin.o == (irq == ctl_s[1]))
      else $error("combined pin not showing the interrupt");
   a_alarm1_level: assert property (s_calm(!ctl_s[0] && ctl_s[2]) |->
      irq_or_input1_alarm_pin.oe && irq_or_input1_alarm_pin.o ==
      (($past(det.los1, 2) || ($past(det.fos1, 2) && ctl_s[5])) == ctl_s[4]))
      else $error("input one alarm level wrong");
   a_comb_tristate: assert property (s_calm(!ctl_s[0] && !ctl_s[2]) |->
      !irq_or_input1_alarm_pin.oe) else $error("combined pin driven with no function");
   a_alarm2_level: assert property (s_calm(ctl_s[3]) |-> input2_alarm_pin.oe &&
      input2_alarm_pin.o == (($past(det.los2, 2) || ($past(det.fos2, 2) && ctl_s[6])) == ctl_s[4]))
      else $error("input two alarm level wrong");
   a_alarm2_tristate: assert property (s_calm(!ctl_s[3]) |-> !input2_alarm_pin.oe)
      else $error("input two pin driven while disabled");
   a_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid ##1 !s_axi_rvalid || !s_axi_rready)
      else $error("read answer not with address accept");
endmodule // cai_top_chk
`default_nettype wire

// >>> test/cai_board.sv
// Board model: drives the low reset and watches the alarm and interrupt lines
`timescale 1ns/10ps
`default_nettype none
module cai_board (
   // Clock and reset request
   input wire logic clock,
   input wire logic rst_req,
   output logic rst_b,
   // Watched pins and resulting line levels
   input wire cai_pkg::cai_pin_t irq_or_input1_alarm_pin,
   input wire cai_pkg::cai_pin_t input2_alarm_pin,
   output logic line1,
   output logic line2
);
   // Reset low from time zero until released, changed only after an edge; one driver
   initial begin
      rst_b = 1'h0;
      forever @(posedge clock) rst_b <= !rst_req;
   end
   // Last level each pin drove, kept while the pin is released
   logic last1 = 1'h0;
   logic last2 = 1'h0;
   // No pull on these lines: a released line settles at the inverse of its last driven level
   always @(posedge clock) begin
      if (irq_or_input1_alarm_pin.oe) last1 <= irq_or_input1_alarm_pin.o;
      if (input2_alarm_pin.oe) last2 <= input2_alarm_pin.o;
      line1 <= irq_or_input1_alarm_pin.oe ? irq_or_input1_alarm_pin.o : !last1;
      line2 <= input2_alarm_pin.oe ? input2_alarm_pin.o : !last2;
   end
endmodule // cai_board
`default_nettype wire

// >>> test/clock_alarm_irq_pins_tb.sv
// Self-checking bench for the alarm/irq pin block
`timescale 1ns/10ps
`default_nettype none
bind cai_top cai_top_chk u_chk (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .det, .irq_or_input1_alarm_pin,
   .input2_alarm_pin, .clk_out_oe, .irq);
module clock_alarm_irq_pins_tb;
   typedef struct packed {
      logic [6:0] c;
      logic [3:0] d;
      cai_pkg::cai_pin_t p1;
      cai_pkg::cai_pin_t p2;
   } cai_row_t;
   logic clock = 1'h0;
   logic rst_req = 1'h1;
   logic rst_b, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, line1, line2;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, clk_out_oe, r;
   cai_pkg::cai_det_t det = 4'h0;
   cai_pkg::cai_pin_t irq_or_input1_alarm_pin, input2_alarm_pin;
   int n_fail = 0;
   int total_checks = 0;
   // Ordinary pin cases: control, detectors, expected pins as {o, oe}
   cai_row_t rows [10] = '{'{7'h00, 4'hF, 2'h0, 2'h0}, '{7'h1C, 4'h0, 2'h1, 2'h1},
      '{7'h1C, 4'h8, 2'h3, 2'h1}, '{7'h1C, 4'h2, 2'h1, 2'h3}, '{7'h0C, 4'h8, 2'h1, 2'h3},
      '{7'h1C, 4'h4, 2'h1, 2'h1}, '{7'h7C, 4'h5, 2'h3, 2'h3}, '{7'h11, 4'h0, 2'h3, 2'h0},
      '{7'h13, 4'h0, 2'h1, 2'h0}, '{7'h17, 4'h8, 2'h1, 2'h0}};
   logic [7:0] rst_regs [4] = '{cai_pkg::CAI_OFF_CTRL, cai_pkg::CAI_OFF_STATUS,
      cai_pkg::CAI_OFF_ENABLE, cai_pkg::CAI_OFF_CLKEN};
   cai_top u_dut (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .det, .irq_or_input1_alarm_pin, .input2_alarm_pin, .clk_out_oe, .irq);
   cai_board u_board (.clock, .rst_req, .rst_b, .irq_or_input1_alarm_pin, .input2_alarm_pin,
      .line1, .line2);
   // ---------------------------------------------------------------
   // Bus tasks and comparison
   // ---------------------------------------------------------------
   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   // Read: request held until accepted, ready held until the answer is sampled
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // Level of a pin with the undriven level masked off
   function automatic logic [1:0] msk(input cai_pkg::cai_pin_t p);
      return {p.o & p.oe, p.oe};
   endfunction
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ---------------------------------------------------------------
   initial begin
      forever #10 clock = ~clock;
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      n_fail++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge clock);
      rst_req <= 1'h0;
      repeat (3) @(posedge clock);
      foreach (rst_regs[i]) begin
         rd(rst_regs[i], d, r);
         chk("reset value", 32'h0, d);
      end
      chk("clk oe at reset", 32'h0, 32'(clk_out_oe));
      $display("test reset defaults done");
      foreach (rows[i]) begin
         wr(cai_pkg::CAI_OFF_CTRL, 32'(rows[i].c), r);
         det <= rows[i].d;
         repeat (4) @(posedge clock);
         chk("pin1", 32'(msk(rows[i].p1)), 32'(msk(irq_or_input1_alarm_pin)));
         chk("pin2", 32'(msk(rows[i].p2)), 32'(msk(input2_alarm_pin)));
         if (rows[i].p1.oe) chk("line1", 32'(rows[i].p1.o), 32'(line1));
         if (rows[i].p2.oe) chk("line2", 32'(rows[i].p2.o), 32'(line2));
      end
      $display("test pin table done");
      det <= 4'h0;
      wr(cai_pkg::CAI_OFF_CLEAR, 32'hF, r);
      det <= 4'h8;
      repeat (4) @(posedge clock);
      rd(cai_pkg::CAI_OFF_LIVE, d, r);
      chk("live", 32'h1, d);
      det <= 4'h0;
      rd(cai_pkg::CAI_OFF_STATUS, d, r);
      chk("status sticky", 32'h1, d);
      chk("irq masked", 32'h0, 32'(irq));
      wr(cai_pkg::CAI_OFF_ENABLE, 32'h1, r);
      wr(cai_pkg::CAI_OFF_CTRL, 32'h03, r);
      repeat (2) @(posedge clock);
      chk("irq raised", 32'h1, 32'(irq));
      chk("irq pin high", 32'h3, 32'(msk(irq_or_input1_alarm_pin)));
      wr(cai_pkg::CAI_OFF_ENABLE, 32'h0, r);
      repeat (2) @(posedge clock);
      chk("irq pin masked", 32'h1, 32'(msk(irq_or_input1_alarm_pin)));
      wr(cai_pkg::CAI_OFF_ENABLE, 32'h1, r);
      wr(cai_pkg::CAI_OFF_CLEAR, 32'h1, r);
      repeat (2) @(posedge clock);
      chk("irq cleared", 32'h0, 32'(irq));
      $display("test interrupt done");
      wr(8'h18, 32'h5, r);
      chk("unmapped write", 32'(cai_pkg::CAI_RESP_SLVERR), 32'(r));
      wr(cai_pkg::CAI_OFF_STATUS, 32'hF, r);
      chk("status write", 32'(cai_pkg::CAI_RESP_SLVERR), 32'(r));
      rd(8'h18, d, r);
      chk("unmapped read", {30'h0, cai_pkg::CAI_RESP_SLVERR}, d | 32'(r));
      $display("test refused access done");
      wr(cai_pkg::CAI_OFF_CLKEN, 32'h3, r);
      wr(cai_pkg::CAI_OFF_CTRL, 32'h0C, r);
      chk("clk oe on", 32'h3, 32'(clk_out_oe));
      rst_req <= 1'h1;
      repeat (3) @(posedge clock);
      chk("clk oe in reset", 32'h0, 32'(clk_out_oe));
      chk("pins in reset", 32'h0, {msk(irq_or_input1_alarm_pin), msk(input2_alarm_pin)});
      rst_req <= 1'h0;
      repeat (3) @(posedge clock);
      rd(cai_pkg::CAI_OFF_CTRL, d, r);
      chk("ctrl after reset", 32'h0, d);
      wr(cai_pkg::CAI_OFF_CLKEN, 32'h3, r);
      @(posedge clock);
      chk("clk oe reprogrammed", 32'h3, 32'(clk_out_oe));
      $display("test mid-run reset done");
      conclude();
   end
endmodule // clock_alarm_irq_pins_tb
`default_nettype wire
